// *** hdl/acr_pkg.sv ***
package acr_pkg;

    localparam int unsigned ADDR_W      = 8;
    localparam int unsigned REG_W       = 8;
    localparam int unsigned FRAME_BITS  = 16;
    localparam int unsigned NUM_REGS    = 15;
    localparam int unsigned IDX_W       = 4;
    localparam int unsigned PAT_W       = 14;
    localparam int unsigned SYNC_N      = 5;

    localparam logic [7:0] REG_RST      = 8'h00;

    // register addresses
    localparam logic [7:0] ADR_CTL      = 8'h00;
    localparam logic [7:0] ADR_SWING    = 8'h01;
    localparam logic [7:0] ADR_PERF1    = 8'h03;
    localparam logic [7:0] ADR_GAIN     = 8'h25;
    localparam logic [7:0] ADR_DRIVE    = 8'h26;
    localparam logic [7:0] ADR_FORMAT   = 8'h3d;
    localparam logic [7:0] ADR_UPAT_HI  = 8'h3f;
    localparam logic [7:0] ADR_UPAT_LO  = 8'h40;
    localparam logic [7:0] ADR_RISE     = 8'h41;
    localparam logic [7:0] ADR_FALL     = 8'h42;
    localparam logic [7:0] ADR_PDN      = 8'h43;
    localparam logic [7:0] ADR_PERF2    = 8'h4a;
    localparam logic [7:0] ADR_PEDESTAL = 8'hbf;
    localparam logic [7:0] ADR_CORR     = 8'hcf;
    localparam logic [7:0] ADR_LOWRATE  = 8'hdf;

    // storage slot of each register
    localparam logic [3:0] IDX_CTL      = 4'h0;
    localparam logic [3:0] IDX_SWING    = 4'h1;
    localparam logic [3:0] IDX_PERF1    = 4'h2;
    localparam logic [3:0] IDX_GAIN     = 4'h3;
    localparam logic [3:0] IDX_DRIVE    = 4'h4;
    localparam logic [3:0] IDX_FORMAT   = 4'h5;
    localparam logic [3:0] IDX_UPAT_HI  = 4'h6;
    localparam logic [3:0] IDX_UPAT_LO  = 4'h7;
    localparam logic [3:0] IDX_RISE     = 4'h8;
    localparam logic [3:0] IDX_FALL     = 4'h9;
    localparam logic [3:0] IDX_PDN      = 4'ha;
    localparam logic [3:0] IDX_PERF2    = 4'hb;
    localparam logic [3:0] IDX_PEDESTAL = 4'hc;
    localparam logic [3:0] IDX_CORR     = 4'hd;
    localparam logic [3:0] IDX_LOWRATE  = 4'he;

    // writable bits of each register, reserved bits stay zero
    localparam logic [7:0] MSK_CTL      = 8'h01;
    localparam logic [7:0] MSK_SWING    = 8'hfc;
    localparam logic [7:0] MSK_PERF1    = 8'h03;
    localparam logic [7:0] MSK_GAIN     = 8'hff;
    localparam logic [7:0] MSK_DRIVE    = 8'h03;
    localparam logic [7:0] MSK_FORMAT   = 8'he0;
    localparam logic [7:0] MSK_UPAT_HI  = 8'hff;
    localparam logic [7:0] MSK_UPAT_LO  = 8'hfc;
    localparam logic [7:0] MSK_RISE     = 8'hff;
    localparam logic [7:0] MSK_FALL     = 8'hcc;
    localparam logic [7:0] MSK_PDN      = 8'h53;
    localparam logic [7:0] MSK_PERF2    = 8'h01;
    localparam logic [7:0] MSK_PEDESTAL = 8'hfc;
    localparam logic [7:0] MSK_CORR     = 8'hbc;
    localparam logic [7:0] MSK_LOWRATE  = 8'h30;

    // field positions
    localparam int unsigned POS_READBACK  = 0;
    localparam int unsigned POS_SOFT_RST  = 1;
    localparam int unsigned POS_GAIN_DIS  = 3;
    localparam int unsigned POS_DIG_EN    = 3;
    localparam int unsigned POS_STANDBY   = 2;
    localparam int unsigned POS_FULL_PDN  = 6;
    localparam int unsigned POS_OBUF_OFF  = 4;
    localparam int unsigned POS_LOOP_EN   = 5;
    localparam int unsigned POS_LOOP_HOLD = 7;
    localparam int unsigned POS_PERF2     = 0;

    localparam logic [5:0] SWING_DEFAULT  = 6'h00;
    localparam logic [1:0] SWING_CTL_ON   = 2'h3;
    localparam logic [3:0] GAIN_NONE      = 4'h0;

    // sync vector slots
    localparam int unsigned S_SCLK = 0;
    localparam int unsigned S_SEL  = 1;
    localparam int unsigned S_SDI  = 2;
    localparam int unsigned S_HRST = 3;
    localparam int unsigned S_OVR  = 4;

    typedef enum logic [2:0] {
        PAT_NORMAL = 3'h0,
        PAT_ZEROS  = 3'h1,
        PAT_ONES   = 3'h2,
        PAT_TOGGLE = 3'h3,
        PAT_RAMP   = 3'h4,
        PAT_USER   = 3'h5
    } acr_pat_t;

    localparam int unsigned RAMP_DIV_NARROW = 4;
    localparam int unsigned RAMP_DIV_WIDE   = 1;
    localparam int unsigned NARROW_W        = 12;

endpackage

// *** hdl/acr_buf.sv ***
`timescale 1ns/1ps
module acr_buf #(
    parameter int unsigned WIDTH = 14,
    parameter int unsigned DEPTH = 2
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int unsigned CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_ff [0:DEPTH-1];
    logic [PW-1:0]    wr_ptr_ff;
    logic [PW-1:0]    rd_ptr_ff;
    logic [CW-1:0]    count_ff;
    logic             push;
    logic             pop;

    assign in_ready  = (count_ff != CW'(DEPTH));
    assign out_valid = (count_ff != '0);
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = mem_ff[rd_ptr_ff];

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        bump = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction

    always_ff @(posedge clk) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= bump(wr_ptr_ff);
            end
            if (pop) begin
                rd_ptr_ff <= bump(rd_ptr_ff);
            end
            if (push && !pop) begin
                count_ff <= count_ff + CW'(1);
            end else if (pop && !push) begin
                count_ff <= count_ff - CW'(1);
            end
        end
    end
endmodule

// *** hdl/acr_cfg.sv ***
`timescale 1ns/1ps
module acr_cfg #(
    parameter int unsigned DATA_W = 14
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              hw_reset,
    input  wire logic              serial_clk_pin,
    input  wire logic              serial_select_n,
    input  wire logic              serial_in_line,
    input  wire logic              overrange_in,
    output logic                   overrange_readback_pin,
    input  wire logic [DATA_W-1:0] adc_data,
    input  wire logic              adc_valid,
    output logic                   adc_ready,
    output logic      [DATA_W-1:0] out_data,
    output logic                   out_valid,
    input  wire logic              out_ready,
    output logic      [5:0]        swing_code,
    output logic      [1:0]        perf_boost_one,
    output logic                   perf_boost_two,
    output logic      [3:0]        gain_code,
    output logic      [1:0]        drive_strength,
    output logic      [1:0]        data_format,
    output logic                   offset_loop_enable,
    output logic                   offset_loop_hold,
    output logic      [3:0]        offset_time_const,
    output logic      [5:0]        offset_pedestal,
    output logic      [7:0]        clkout_rise_cfg,
    output logic      [1:0]        clkout_fall_pos,
    output logic                   standby_request,
    output logic                   full_power_down,
    output logic                   output_buffer_off,
    output logic      [1:0]        low_rate_sel,
    output logic                   digital_path_enable
);
    localparam int unsigned RAMP_DIV = (DATA_W == acr_pkg::NARROW_W) ?
                                       acr_pkg::RAMP_DIV_NARROW : acr_pkg::RAMP_DIV_WIDE;

    // storage slot lookup: {hit, index}
    function automatic logic [4:0] decode(input logic [7:0] a);
        if (a == acr_pkg::ADR_CTL) begin
            decode = {1'b1, acr_pkg::IDX_CTL};
        end else if (a == acr_pkg::ADR_SWING) begin
            decode = {1'b1, acr_pkg::IDX_SWING};
        end else if (a == acr_pkg::ADR_PERF1) begin
            decode = {1'b1, acr_pkg::IDX_PERF1};
        end else if (a == acr_pkg::ADR_GAIN) begin
            decode = {1'b1, acr_pkg::IDX_GAIN};
        end else if (a == acr_pkg::ADR_DRIVE) begin
            decode = {1'b1, acr_pkg::IDX_DRIVE};
        end else if (a == acr_pkg::ADR_FORMAT) begin
            decode = {1'b1, acr_pkg::IDX_FORMAT};
        end else if (a == acr_pkg::ADR_UPAT_HI) begin
            decode = {1'b1, acr_pkg::IDX_UPAT_HI};
        end else if (a == acr_pkg::ADR_UPAT_LO) begin
            decode = {1'b1, acr_pkg::IDX_UPAT_LO};
        end else if (a == acr_pkg::ADR_RISE) begin
            decode = {1'b1, acr_pkg::IDX_RISE};
        end else if (a == acr_pkg::ADR_FALL) begin
            decode = {1'b1, acr_pkg::IDX_FALL};
        end else if (a == acr_pkg::ADR_PDN) begin
            decode = {1'b1, acr_pkg::IDX_PDN};
        end else if (a == acr_pkg::ADR_PERF2) begin
            decode = {1'b1, acr_pkg::IDX_PERF2};
        end else if (a == acr_pkg::ADR_PEDESTAL) begin
            decode = {1'b1, acr_pkg::IDX_PEDESTAL};
        end else if (a == acr_pkg::ADR_CORR) begin
            decode = {1'b1, acr_pkg::IDX_CORR};
        end else if (a == acr_pkg::ADR_LOWRATE) begin
            decode = {1'b1, acr_pkg::IDX_LOWRATE};
        end else begin
            decode = 5'h00;
        end
    endfunction

    function automatic logic [7:0] wr_mask(input logic [3:0] i);
        case (i)
            acr_pkg::IDX_CTL:      wr_mask = acr_pkg::MSK_CTL;
            acr_pkg::IDX_SWING:    wr_mask = acr_pkg::MSK_SWING;
            acr_pkg::IDX_PERF1:    wr_mask = acr_pkg::MSK_PERF1;
            acr_pkg::IDX_GAIN:     wr_mask = acr_pkg::MSK_GAIN;
            acr_pkg::IDX_DRIVE:    wr_mask = acr_pkg::MSK_DRIVE;
            acr_pkg::IDX_FORMAT:   wr_mask = acr_pkg::MSK_FORMAT;
            acr_pkg::IDX_UPAT_HI:  wr_mask = acr_pkg::MSK_UPAT_HI;
            acr_pkg::IDX_UPAT_LO:  wr_mask = acr_pkg::MSK_UPAT_LO;
            acr_pkg::IDX_RISE:     wr_mask = acr_pkg::MSK_RISE;
            acr_pkg::IDX_FALL:     wr_mask = acr_pkg::MSK_FALL;
            acr_pkg::IDX_PDN:      wr_mask = acr_pkg::MSK_PDN;
            acr_pkg::IDX_PERF2:    wr_mask = acr_pkg::MSK_PERF2;
            acr_pkg::IDX_PEDESTAL: wr_mask = acr_pkg::MSK_PEDESTAL;
            acr_pkg::IDX_CORR:     wr_mask = acr_pkg::MSK_CORR;
            acr_pkg::IDX_LOWRATE:  wr_mask = acr_pkg::MSK_LOWRATE;
            default:               wr_mask = 8'h00;
        endcase
    endfunction

    // 0101.. word; inverted gives 1010..
    function automatic logic [DATA_W-1:0] alt_word();
        logic [DATA_W-1:0] w;
        w = '0;
        for (int i = 0; i < DATA_W; i++) begin
            w[i] = ((i % 2) == 0);
        end
        alt_word = w;
    endfunction

    // pin inputs through two flops
    logic [acr_pkg::SYNC_N-1:0] meta_ff;
    logic [acr_pkg::SYNC_N-1:0] sync_ff;
    logic                       sclk_prev_ff;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_ff      <= 5'h00;
            sync_ff      <= 5'h00;
            sclk_prev_ff <= 1'b0;
        end else begin
            meta_ff      <= {overrange_in, hw_reset, serial_in_line,
                             serial_select_n, serial_clk_pin};
            sync_ff      <= meta_ff;
            sclk_prev_ff <= sync_ff[acr_pkg::S_SCLK];
        end
    end

    logic sclk_fall;
    logic sel_act;
    logic sdi_bit;
    logic hrst;

    assign sclk_fall = sclk_prev_ff & ~sync_ff[acr_pkg::S_SCLK];
    assign sel_act   = ~sync_ff[acr_pkg::S_SEL];
    assign sdi_bit   = sync_ff[acr_pkg::S_SDI];
    assign hrst      = sync_ff[acr_pkg::S_HRST];

    // serial frame shifter
    logic [14:0] shift_ff;
    logic [3:0]  bit_cnt_ff;
    logic [7:0]  rd_shift_ff;
    logic        pin_ff;
    logic [7:0]  regs_ff [0:acr_pkg::NUM_REGS-1];

    logic        take_bit;
    logic [15:0] frame;
    logic        frame_done;
    logic        addr_done;
    logic [7:0]  wr_addr;
    logic [7:0]  wr_data;
    logic [4:0]  wr_dec;
    logic [4:0]  rd_dec;
    logic [7:0]  rd_addr;
    logic [7:0]  rd_value;
    logic        readback;
    logic        wr_ok;
    logic        soft_rst;
    logic        clear_all;

    assign take_bit   = sclk_fall & sel_act;
    assign frame      = {shift_ff, sdi_bit};
    assign frame_done = take_bit && (bit_cnt_ff == 4'hf);
    assign addr_done  = take_bit && (bit_cnt_ff == 4'h7);
    assign wr_addr    = frame[15:8];
    assign wr_data    = frame[7:0];
    assign wr_dec     = decode(wr_addr);
    assign rd_addr    = frame[7:0];
    assign rd_dec     = decode(rd_addr);
    assign readback   = regs_ff[acr_pkg::IDX_CTL][acr_pkg::POS_READBACK];
    assign wr_ok      = frame_done && wr_dec[4] &&
                        (!readback || (wr_addr == acr_pkg::ADR_CTL));
    assign soft_rst   = frame_done && (wr_addr == acr_pkg::ADR_CTL) &&
                        wr_data[acr_pkg::POS_SOFT_RST];
    assign clear_all  = hrst | soft_rst;
    assign rd_value   = (rd_dec[4] && rd_addr != acr_pkg::ADR_CTL) ?
                        regs_ff[rd_dec[3:0]] : 8'h00;

    always_ff @(posedge clk) begin
        if (!rst_n || !sel_act) begin
            shift_ff   <= 15'h0000;
            bit_cnt_ff <= 4'h0;
        end else if (take_bit) begin
            shift_ff   <= frame[14:0];
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_shift_ff <= 8'h00;
            pin_ff      <= 1'b0;
        end else begin
            if (addr_done) begin
                rd_shift_ff <= rd_value;
            end else if (take_bit) begin
                rd_shift_ff <= {rd_shift_ff[6:0], 1'b0};
            end
            pin_ff <= readback ? rd_shift_ff[7] : sync_ff[acr_pkg::S_OVR];
        end
    end

    assign overrange_readback_pin = pin_ff;

    always_ff @(posedge clk) begin
        if (!rst_n || clear_all) begin
            for (int i = 0; i < acr_pkg::NUM_REGS; i++) begin
                regs_ff[i] <= acr_pkg::REG_RST;
            end
        end else if (wr_ok) begin
            regs_ff[wr_dec[3:0]] <= wr_data & wr_mask(wr_dec[3:0]);
        end
    end

    // decoded control fields
    logic [7:0] r_gain;
    logic [7:0] r_fall;
    logic [7:0] r_pdn;
    logic [7:0] r_corr;
    logic       dig_en;

    assign r_gain = regs_ff[acr_pkg::IDX_GAIN];
    assign r_fall = regs_ff[acr_pkg::IDX_FALL];
    assign r_pdn  = regs_ff[acr_pkg::IDX_PDN];
    assign r_corr = regs_ff[acr_pkg::IDX_CORR];
    assign dig_en = r_fall[acr_pkg::POS_DIG_EN];

    assign swing_code = (r_pdn[1:0] == acr_pkg::SWING_CTL_ON) ?
                        regs_ff[acr_pkg::IDX_SWING][7:2] : acr_pkg::SWING_DEFAULT;
    assign perf_boost_one      = regs_ff[acr_pkg::IDX_PERF1][1:0];
    assign perf_boost_two      = regs_ff[acr_pkg::IDX_PERF2][acr_pkg::POS_PERF2];
    assign gain_code           = (dig_en && !r_gain[acr_pkg::POS_GAIN_DIS]) ?
                                 r_gain[7:4] : acr_pkg::GAIN_NONE;
    assign drive_strength      = regs_ff[acr_pkg::IDX_DRIVE][1:0];
    assign data_format         = regs_ff[acr_pkg::IDX_FORMAT][7:6];
    assign offset_loop_enable  = dig_en &
                                 regs_ff[acr_pkg::IDX_FORMAT][acr_pkg::POS_LOOP_EN];
    assign offset_loop_hold    = r_corr[acr_pkg::POS_LOOP_HOLD];
    assign offset_time_const   = r_corr[5:2];
    assign offset_pedestal     = regs_ff[acr_pkg::IDX_PEDESTAL][7:2];
    assign clkout_rise_cfg     = regs_ff[acr_pkg::IDX_RISE];
    assign clkout_fall_pos     = r_fall[7:6];
    assign standby_request     = r_fall[acr_pkg::POS_STANDBY];
    assign full_power_down     = r_pdn[acr_pkg::POS_FULL_PDN];
    assign output_buffer_off   = r_pdn[acr_pkg::POS_OBUF_OFF];
    assign low_rate_sel        = regs_ff[acr_pkg::IDX_LOWRATE][5:4];
    assign digital_path_enable = dig_en;

    // pattern generator
    logic [DATA_W-1:0] ramp_ff;
    logic [1:0]        ramp_div_ff;
    logic              toggle_ff;
    logic              sample_take;
    logic [2:0]        pat;
    logic [13:0]       user_word;
    logic [DATA_W-1:0] pat_word;
    logic [DATA_W-1:0] sel_word;
    logic              use_pat;

    assign sample_take = adc_valid & adc_ready;
    assign pat         = r_gain[2:0];
    assign user_word   = {regs_ff[acr_pkg::IDX_UPAT_HI], regs_ff[acr_pkg::IDX_UPAT_LO][7:2]};
    assign use_pat     = dig_en && (pat != acr_pkg::PAT_NORMAL) && (pat <= acr_pkg::PAT_USER);

    assign pat_word = (pat == acr_pkg::PAT_ZEROS)  ? '0 :
                      (pat == acr_pkg::PAT_ONES)   ? '1 :
                      (pat == acr_pkg::PAT_TOGGLE) ? (toggle_ff ? ~alt_word() : alt_word()) :
                      (pat == acr_pkg::PAT_RAMP)   ? ramp_ff :
                      user_word[13 -: DATA_W];
    assign sel_word = use_pat ? pat_word : adc_data;

    always_ff @(posedge clk) begin
        if (!rst_n || clear_all) begin
            ramp_ff     <= '0;
            ramp_div_ff <= 2'h0;
            toggle_ff   <= 1'b0;
        end else if (sample_take) begin
            toggle_ff <= ~toggle_ff;
            if (ramp_div_ff == 2'(RAMP_DIV - 1)) begin
                ramp_div_ff <= 2'h0;
                ramp_ff     <= ramp_ff + DATA_W'(1);
            end else begin
                ramp_div_ff <= ramp_div_ff + 2'h1;
            end
        end
    end

    acr_buf #(
        .WIDTH (DATA_W),
        .DEPTH (2)
    ) u_buf (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (adc_valid),
        .in_ready  (adc_ready),
        .in_data   (sel_word),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (out_data)
    );
endmodule

// *** dv/acr_cfg_assertions.sv ***
`timescale 1ns/1ps
module acr_chk #(
    parameter int unsigned DATA_W = 14
) (
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic              hw_reset,
    input wire logic              serial_select_n,
    input wire logic [DATA_W-1:0] adc_data,
    input wire logic              adc_valid,
    input wire logic              adc_ready,
    input wire logic [DATA_W-1:0] out_data,
    input wire logic              out_valid,
    input wire logic              out_ready,
    input wire logic [5:0]        swing_code,
    input wire logic [3:0]        gain_code,
    input wire logic [1:0]        drive_strength,
    input wire logic              offset_loop_enable,
    input wire logic              digital_path_enable
);
    logic [3:0]  idle_ff;
    logic [3:0]  nxt_idle;
    logic [12:0] cfg;
    assign cfg = {swing_code, gain_code, drive_strength, digital_path_enable};
    // cycles with link idle and no hardware reset
    assign nxt_idle = !(serial_select_n && !hw_reset) ? 4'h0 :
                      (idle_ff == 4'hf) ? idle_ff : idle_ff + 4'h1;
    always_ff @(posedge clk) begin
        idle_ff <= rst_n ? nxt_idle : 4'h0;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_take; adc_valid && adc_ready; endsequence
    sequence s_hw; hw_reset [*4]; endsequence
    property p_reset_zero; $rose(rst_n) |-> cfg == 13'h0 && adc_ready && !out_valid; endproperty
    property p_hw_zero; s_hw |=> cfg == 13'h0; endproperty
    property p_quiet; idle_ff >= 4'h8 |-> $stable(cfg); endproperty
    property p_take; s_take |=> out_valid; endproperty
    property p_hold; out_valid && !out_ready |=> out_valid && $stable(out_data); endproperty
    property p_bypass;
        (!digital_path_enable && !out_valid) ##0 s_take |=> out_data == $past(adc_data);
    endproperty
    property p_gain; gain_code != 4'h0 |-> digital_path_enable; endproperty
    property p_loop; offset_loop_enable |-> digital_path_enable; endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("config not reset");
    a_hw_zero: assert property (p_hw_zero) else $error("config kept after pin reset");
    a_quiet: assert property (p_quiet) else $error("config changed with link idle");
    a_take: assert property (p_take) else $error("accepted word not presented");
    a_hold: assert property (p_hold) else $error("output word dropped in stall");
    a_bypass: assert property (p_bypass) else $error("path off but data altered");
    a_gain: assert property (p_gain) else $error("gain active with digital path off");
    a_loop: assert property (p_loop) else $error("offset loop active with path off");
endmodule
bind acr_cfg acr_chk #(.DATA_W(DATA_W)) u_chk (.clk, .rst_n, .hw_reset, .serial_select_n,
    .adc_data, .adc_valid, .adc_ready, .out_data, .out_valid, .out_ready, .swing_code,
    .gain_code, .drive_strength, .offset_loop_enable, .digital_path_enable);

// *** dv/acr_ctl_model.sv ***
`timescale 1ns/1ps
module acr_ctl_model (
    output logic      serial_clk_pin,
    output logic      serial_select_n,
    output logic      serial_in_line,
    input  wire logic overrange_readback_pin
);
    initial begin
        serial_clk_pin = 1'b0;
        serial_select_n = 1'b1;
        serial_in_line = 1'b1;
    end
    task automatic frame(input logic [7:0] adr, input logic [7:0] dat, output logic [7:0] rd);
        logic [15:0] w;
        w = {adr, dat};
        rd = 8'h00;
        // keep pin changes off the system clock edge
        #7;
        serial_select_n = 1'b0;
        #437;
        for (int i = 15; i >= 0; i--) begin
            serial_in_line = w[i];
            serial_clk_pin = 1'b1;
            #400;
            if (i < 8) rd = {rd[6:0], overrange_readback_pin};
            serial_clk_pin = 1'b0;
            #400;
        end
        #400;
        serial_select_n = 1'b1;
        // released line shows no stale bit
        serial_in_line = ~serial_in_line;
        // select stays high between frames
        #800;
    endtask
endmodule

// *** dv/acr_tb.sv ***
`timescale 1ns/1ps
module testbench;
    localparam int unsigned DW = 14;
    logic clk = 1'b0, rst_n = 1'b0, hw_reset = 1'b0, overrange_in = 1'b0;
    logic adc_valid = 1'b0, out_ready = 1'b0, gen_on = 1'b0;
    logic [DW-1:0] adc_data = '0, ramp = '0;
    logic tog = 1'b0;
    logic [2:0] ovr_h = 3'h0;
    logic serial_clk_pin, serial_select_n, serial_in_line, overrange_readback_pin;
    logic adc_ready, out_valid, perf_boost_two, offset_loop_enable, offset_loop_hold;
    logic standby_request, full_power_down, output_buffer_off, digital_path_enable;
    logic [DW-1:0] out_data, e;
    logic [5:0] swing_code, offset_pedestal;
    logic [3:0] gain_code, offset_time_const;
    logic [1:0] perf_boost_one, drive_strength, data_format, clkout_fall_pos, low_rate_sel;
    logic [7:0] clkout_rise_cfg, rd;
    logic [2:0] mode = 3'h0;
    logic [31:0] lfsr = 32'h99254f63;
    logic [DW-1:0] expq[$];
    logic [5:0] sw[6] = '{6'h00, 6'h1b, 6'h32, 6'h14, 6'h3e, 6'h0f};
    int errors = 0, cmp_count = 0;
    wire [44:0] cfg_all = {swing_code, perf_boost_one, perf_boost_two, gain_code, drive_strength,
        data_format, offset_loop_enable, offset_loop_hold, offset_time_const, offset_pedestal,
        clkout_rise_cfg, clkout_fall_pos, standby_request, full_power_down, output_buffer_off,
        low_rate_sel, digital_path_enable};
    acr_cfg #(.DATA_W(DW)) dut (.*);
    acr_ctl_model model (.*);
    always #50 clk = ~clk;
    function automatic logic [31:0] step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string n, input logic [44:0] x, input logic [44:0] g);
        cmp_count++;
        if (g !== x) begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        model.frame(a, d, rd);
        repeat (10) @(posedge clk);
    endtask
    task automatic run(input logic [2:0] m);
        mode = m;
        gen_on <= 1'b1;
        repeat (60) @(posedge clk);
        gen_on <= 1'b0;
        repeat (60) @(posedge clk);
        chk("pending words", 45'h0, 45'(expq.size()));
    endtask
    always @(posedge clk) begin
        lfsr <= step(lfsr);
        adc_valid <= gen_on & lfsr[0];
        adc_data <= lfsr[DW:1];
        out_ready <= lfsr[5] & lfsr[6];
        overrange_in <= lfsr[9];
        // pin follows over-range three clocks late
        ovr_h <= {ovr_h[1:0], overrange_in};
        if (gen_on) chk("overrange pin", 45'(ovr_h[2]), 45'(overrange_readback_pin));
        if (adc_valid && adc_ready) begin
            // toggle phase flips on every accepted sample
            tog <= ~tog;
            expq.push_back(mode == 3'h1 ? 14'h0 : mode == 3'h2 ? 14'h3fff :
                mode == 3'h3 ? (tog ? 14'h2aaa : 14'h1555) : mode == 3'h4 ? ramp :
                mode == 3'h5 ? 14'h2af3 : adc_data);
            if (mode == 3'h4) ramp <= ramp + 1'b1;
        end
        if (out_valid && out_ready) begin
            e = expq.size() ? expq.pop_front() : 14'h1;
            chk("out_data", 45'(e), 45'(out_data));
        end
    end
    initial begin
        #3000000;
        errors++;
        give_verdict();
    end
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk("reset config", 45'h0, cfg_all);
        wr(8'h42, 8'h08);
        wr(8'h25, 8'h04);
        run(3'h4);
        wr(8'h3f, 8'hab);
        wr(8'h40, 8'hcc);
        for (int m = 0; m < 8; m++) begin
            if (m != 4) begin
                wr(8'h25, 8'(m));
                run(3'(m));
            end
        end
        for (int g = 0; g < 13; g++) begin
            wr(8'h25, {4'(g), 4'h0});
            chk("gain_code", 45'(g), 45'(gain_code));
        end
        wr(8'h25, 8'hc8);
        chk("gain_code", 45'h0, 45'(gain_code));
        wr(8'h25, 8'hc2);
        wr(8'h42, 8'h00);
        chk("gain_code", 45'h0, 45'(gain_code));
        run(3'h0);
        wr(8'h42, 8'hcc);
        chk("reg42 fields", 45'h7, 45'({clkout_fall_pos, standby_request}));
        wr(8'h3d, 8'he0);
        chk("format loop", 45'h7, 45'({data_format, offset_loop_enable}));
        wr(8'h03, 8'h03);
        wr(8'h4a, 8'h01);
        chk("perf bits", 45'h7, 45'({perf_boost_one, perf_boost_two}));
        wr(8'h01, 8'h6c);
        chk("swing_code", 45'h0, 45'(swing_code));
        wr(8'h43, 8'h03);
        for (int i = 0; i < 6; i++) begin
            wr(8'h01, {sw[i], 2'b00});
            chk("swing_code", 45'(sw[i]), 45'(swing_code));
        end
        wr(8'h26, 8'h03);
        wr(8'h02, 8'hff);
        chk("drive_strength", 45'h3, 45'(drive_strength));
        wr(8'h00, 8'h01);
        model.frame(8'h26, 8'h00, rd);
        chk("readback 26", 45'h03, 45'(rd));
        model.frame(8'h01, 8'h00, rd);
        chk("readback 01", 45'h3c, 45'(rd));
        model.frame(8'h02, 8'h00, rd);
        chk("readback 02", 45'h0, 45'(rd));
        model.frame(8'h00, 8'h01, rd);
        chk("readback 00", 45'h0, 45'(rd));
        chk("drive_strength", 45'h3, 45'(drive_strength));
        wr(8'h00, 8'h02);
        chk("soft reset config", 45'h0, cfg_all);
        wr(8'h26, 8'h01);
        chk("drive_strength", 45'h1, 45'(drive_strength));
        hw_reset <= 1'b1;
        repeat (4) @(posedge clk);
        hw_reset <= 1'b0;
        repeat (4) @(posedge clk);
        chk("pin reset config", 45'h0, cfg_all);
        give_verdict();
    end
endmodule
